// ### mmpc_bank.sv
// Mesh MAC parameter and diagnostic counter bank
//
// Function
// - Count retry-exhausted transmissions, saturate at max
// - Host preset loads failure counter value
// - Count ack-requesting unicasts, saturating, presettable
// - Read-only unicast hop timeout, default 0xF3
// - Read-only broadcast hop timeout, default 0x204
// - Routing role accepts 0 to 6 except 5
// - Indirect coordinator holds unicasts until polled
// - Pollers poll; routing roles repeat broadcasts
// - Compat bit 2 selects ECB128 versus CTR256
// - Broadcast hops 0 to 0x20, zero means network hops
// - Broadcast hops above network hops clamp
// - Network hops 1 to 0x20 scale timeouts
// - Delay slots limit 1 to 5, default 3
// - Nonzero mesh retries request acks at high rate only, tries plus one
// - Zero mesh retries disable network acks
// - Factory address as two read-only halves
// - Destination halves concatenate, default broadcast
// - Transmit option bits 7:6 choose delivery
// - Low option bits control ack, discovery, nack, trace
// - Rate zero disables mesh and repeater delivery
// - Per-frame options replace stored options
// - Rate setting selects 10 or 80 kb/s
`timescale 1ns/100ps
`include "mmpc_cfg.svh"
module mmpc_bank (
    input  wire logic                clock,         // System clock, 100 MHz
    input  wire logic                rst_n,         // Async reset, active low
    input  wire logic                ce,            // Clock enable, freezes all state
    input  wire mmpc_pkg::mmpc_cmd_t cmd,           // Command from serial decoder
    input  wire logic [63:0]         factory_addr,  // Factory extended address
    input  wire logic                tx_retry_fail, // MAC retries exhausted
    input  wire logic                tx_ack_unicast, // Unicast asking for ack sent
    input  wire logic                frame_opt_valid, // Per-frame options present
    input  wire logic [7:0]          per_frame_tx_options, // Per-frame options
    output mmpc_pkg::mmpc_rsp_t      rsp,           // Command answer
    output mmpc_pkg::mmpc_eff_t      eff,           // Effective settings
    output logic                     rf_rate_high,  // High data rate selected
    output logic [15:0]              unicast_hop_timeout,  // Read-only timeout
    output logic [15:0]              broadcast_hop_timeout // Read-only timeout
);
    // Stored parameters
    logic [7:0]  routing_role;            // Messaging role
    logic [7:0]  compat_options;          // Compatibility bits
    logic [7:0]  broadcast_hop_limit;     // Broadcast hops
    logic [7:0]  network_hop_setting;     // Network hops
    logic [7:0]  rebroadcast_delay_slots; // Max delay slots
    logic [7:0]  mesh_retry_limit;        // Mesh retries
    logic [31:0] dest_address_upper;      // Destination high
    logic [31:0] dest_address_lower;      // Destination low
    logic [7:0]  transmit_options;        // Stored transmit options
    logic        rf_rate_select;          // Data rate setting
    logic [31:0] own_address_upper;       // Captured factory high
    logic [31:0] own_address_lower;       // Captured factory low
    logic        addr_caught;             // Factory address captured
    logic [15:0] tx_failure_count;        // Failure counter
    logic [15:0] unicast_ack_request_count; // Unicast counter
    logic        next_err;                // Rejection of current command
    logic [31:0] next_rdata;              // Read mux output
    logic [7:0]  opt_src;                 // Options in force for frame
    logic [7:0]  bh_eff;                  // Effective broadcast hops
    logic [7:0]  opt_eff;                 // Options in force after the rate filter

    // Strip delivery methods the low rate cannot carry
    function automatic logic [7:0] rate_filter(input logic [7:0] opt, input logic rate);
        logic [7:0] o;
        o = opt;
        if (!rate) begin
            o[`MMPC_TXO_DM_HI] = 1'b0;
            o[`MMPC_TXO_DM_LO] = 1'b1;
        end
        return o;
    endfunction : rate_filter

    // Range check used by every bounded byte setting
    function automatic logic in_range(input logic [31:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return (v[31:8] == 24'h0) && (v[7:0] >= lo) && (v[7:0] <= hi);
    endfunction : in_range

    // Failure counter
    mmpc_sat_counter u_fail (
        .clock      (clock),
        .rst_n      (rst_n),
        .ce         (ce),
        .load       (cmd.wr && cmd.idx == `MMPC_IDX_TXFAIL && !next_err),
        .load_value (cmd.data[15:0]),
        .event_in   (tx_retry_fail),
        .count      (tx_failure_count)
    );

    // Unicast request counter
    mmpc_sat_counter u_ucreq (
        .clock      (clock),
        .rst_n      (rst_n),
        .ce         (ce),
        .load       (cmd.wr && cmd.idx == `MMPC_IDX_UCREQ && !next_err),
        .load_value (cmd.data[15:0]),
        .event_in   (tx_ack_unicast),
        .count      (unicast_ack_request_count)
    );

    // Validate a write; read-only and unknown indices are refused
    always_comb begin
        next_err = 1'b0;
        unique case (cmd.idx)
            `MMPC_IDX_TXFAIL, `MMPC_IDX_UCREQ: next_err = cmd.data[31:16] != 16'h0;
            `MMPC_IDX_ROLE:   next_err = !in_range(cmd.data, 8'h00, `MMPC_ROLE_MAX)
                                         || cmd.data[7:0] == `MMPC_ROLE_UNUSED;
            `MMPC_IDX_COMPAT: next_err = cmd.data[31:8] != 24'h0;
            `MMPC_IDX_BHOPS:  next_err = !in_range(cmd.data, 8'h00, `MMPC_HOPS_MAX);
            `MMPC_IDX_NHOPS:  next_err = !in_range(cmd.data, 8'h01, `MMPC_HOPS_MAX);
            `MMPC_IDX_SLOTS:  next_err = !in_range(cmd.data, 8'h01, `MMPC_SLOTS_MAX);
            `MMPC_IDX_MRETRY: next_err = !in_range(cmd.data, 8'h00, `MMPC_MRETRY_MAX);
            `MMPC_IDX_DESTHI, `MMPC_IDX_DESTLO: next_err = 1'b0;
            `MMPC_IDX_TXOPT:  next_err = cmd.data[31:8] != 24'h0
                                         || cmd.data[`MMPC_TXO_DM_HI:`MMPC_TXO_DM_LO] == 2'b00
                                         || cmd.data[`MMPC_TXO_RSV_HI:`MMPC_TXO_RSV_LO] != 2'b00;
            `MMPC_IDX_RATE:   next_err = cmd.data[31:1] != 31'h0;
            default:          next_err = 1'b1;
        endcase
    end

    // Read multiplexer
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (cmd.idx)
            `MMPC_IDX_TXFAIL: next_rdata = {16'h0, tx_failure_count};
            `MMPC_IDX_UCREQ:  next_rdata = {16'h0, unicast_ack_request_count};
            `MMPC_IDX_UCHOP:  next_rdata = {16'h0, unicast_hop_timeout};
            `MMPC_IDX_BCHOP:  next_rdata = {16'h0, broadcast_hop_timeout};
            `MMPC_IDX_ROLE:   next_rdata = {24'h0, routing_role};
            `MMPC_IDX_COMPAT: next_rdata = {24'h0, compat_options};
            `MMPC_IDX_BHOPS:  next_rdata = {24'h0, broadcast_hop_limit};
            `MMPC_IDX_NHOPS:  next_rdata = {24'h0, network_hop_setting};
            `MMPC_IDX_SLOTS:  next_rdata = {24'h0, rebroadcast_delay_slots};
            `MMPC_IDX_MRETRY: next_rdata = {24'h0, mesh_retry_limit};
            `MMPC_IDX_OWNHI:  next_rdata = own_address_upper;
            `MMPC_IDX_OWNLO:  next_rdata = own_address_lower;
            `MMPC_IDX_DESTHI: next_rdata = dest_address_upper;
            `MMPC_IDX_DESTLO: next_rdata = dest_address_lower;
            `MMPC_IDX_TXOPT:  next_rdata = {24'h0, transmit_options};
            `MMPC_IDX_RATE:   next_rdata = {31'h0, rf_rate_select};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // Byte settings written by the host
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            routing_role            <= `MMPC_RST_ROLE;
            compat_options          <= `MMPC_RST_COMPAT;
            broadcast_hop_limit     <= `MMPC_RST_BHOPS;
            network_hop_setting     <= `MMPC_RST_NHOPS;
            rebroadcast_delay_slots <= `MMPC_RST_SLOTS;
            mesh_retry_limit        <= `MMPC_RST_MRETRY;
        end else if (ce && cmd.wr && !next_err) begin
            unique case (cmd.idx)
                `MMPC_IDX_ROLE:   routing_role            <= cmd.data[7:0];
                // Other bits are stored as given; keeping them zero is the host's job
                `MMPC_IDX_COMPAT: compat_options          <= cmd.data[7:0];
                `MMPC_IDX_BHOPS:  broadcast_hop_limit     <= cmd.data[7:0];
                `MMPC_IDX_NHOPS:  network_hop_setting     <= cmd.data[7:0];
                `MMPC_IDX_SLOTS:  rebroadcast_delay_slots <= cmd.data[7:0];
                `MMPC_IDX_MRETRY: mesh_retry_limit        <= cmd.data[7:0];
                default: ;
            endcase
        end
    end

    // Destination, rate and transmit options
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dest_address_upper <= `MMPC_RST_DESTHI;
            dest_address_lower <= `MMPC_RST_DESTLO;
            transmit_options   <= `MMPC_RST_TXOPT_R1;
            rf_rate_select     <= `MMPC_RST_RATE;
        end else if (ce && cmd.wr && !next_err) begin
            unique case (cmd.idx)
                `MMPC_IDX_DESTHI: dest_address_upper <= cmd.data;
                `MMPC_IDX_DESTLO: dest_address_lower <= cmd.data;
                `MMPC_IDX_TXOPT:  transmit_options   <= rate_filter(cmd.data[7:0], rf_rate_select);
                `MMPC_IDX_RATE: begin
                    rf_rate_select   <= cmd.data[0];
                    // Any rate write restores the rate's default transmit options
                    transmit_options <= cmd.data[0] ? `MMPC_RST_TXOPT_R1 : `MMPC_RST_TXOPT_R0;
                end
                default: ;
            endcase
        end
    end

    // Factory address caught once after reset release, never writable
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            own_address_upper <= 32'h0000_0000;
            own_address_lower <= 32'h0000_0000;
            addr_caught       <= 1'b0;
        end else if (ce && !addr_caught) begin
            own_address_upper <= factory_addr[63:32];
            own_address_lower <= factory_addr[31:0];
            addr_caught       <= 1'b1;
        end
    end

    // Timeouts grow with network hops; defaults hold at the default hop count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            unicast_hop_timeout   <= `MMPC_RST_UCHOP;
            broadcast_hop_timeout <= `MMPC_RST_BCHOP;
        end else if (ce) begin
            unicast_hop_timeout   <= `MMPC_RST_UCHOP + 16'(network_hop_setting) * `MMPC_UCHOP_STEP
                                     - 16'(`MMPC_RST_NHOPS) * `MMPC_UCHOP_STEP;
            broadcast_hop_timeout <= `MMPC_RST_BCHOP + 16'(network_hop_setting) * `MMPC_BCHOP_STEP
                                     - 16'(`MMPC_RST_NHOPS) * `MMPC_BCHOP_STEP;
        end
    end

    // Per-frame options replace stored ones, still filtered by rate
    assign opt_src = frame_opt_valid ? per_frame_tx_options : transmit_options;
    // Low rate strips mesh and repeater delivery from whichever options are in force
    assign opt_eff = rate_filter(opt_src, rf_rate_select);
    // Zero or too high broadcast hops fall back to network hops
    assign bh_eff = (broadcast_hop_limit == 8'h00 || broadcast_hop_limit > network_hop_setting)
                    ? network_hop_setting : broadcast_hop_limit;

    // Effective settings, registered so every output is a flop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            eff          <= '0;
            rf_rate_high <= 1'b0;
        end else if (ce) begin
            eff.dm         <= mmpc_pkg::mmpc_dm_t'(opt_eff[`MMPC_TXO_DM_HI:`MMPC_TXO_DM_LO]);
            eff.no_ack     <= opt_eff[`MMPC_TXO_NOACK];
            eff.no_rd      <= opt_eff[`MMPC_TXO_NORD];
            eff.nack       <= opt_eff[`MMPC_TXO_NACK];
            eff.trace      <= opt_eff[`MMPC_TXO_TRACE];
            eff.enc_ecb    <= compat_options[`MMPC_COMPAT_ENC];
            eff.routing    <= routing_role == 8'h00 || routing_role == 8'h01 || routing_role == 8'h04;
            eff.coord_hold <= routing_role == 8'h01 || routing_role == 8'h03;
            eff.poller     <= routing_role == 8'h04 || routing_role == 8'h06;
            eff.net_ack    <= mesh_retry_limit != 8'h00 && rf_rate_select;
            eff.net_tries  <= mesh_retry_limit[3:0] + 4'h1;
            eff.bc_hops    <= bh_eff;
            eff.max_slots  <= rebroadcast_delay_slots;
            eff.dest       <= {dest_address_upper, dest_address_lower};
            rf_rate_high   <= rf_rate_select;
        end
    end

    // Command answer one cycle after the request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp <= '0;
        end else if (ce) begin
            rsp.valid <= cmd.wr || cmd.rd;
            rsp.err   <= cmd.wr ? next_err : (cmd.rd && cmd.idx > `MMPC_IDX_RATE);
            rsp.data  <= cmd.rd ? next_rdata : 32'h0000_0000;
        end
    end
endmodule : mmpc_bank

// ### mmpc_bank_monitor.sv
// Checker of the mesh parameter and counter bank, bound to its ports
`timescale 1ns/100ps
module mmpc_bank_monitor (
    input wire logic                clock,        // System clock
    input wire logic                rst_n,        // Async reset, active low
    input wire logic                ce,           // Clock enable
    input wire mmpc_pkg::mmpc_cmd_t cmd,          // Command in
    input wire mmpc_pkg::mmpc_rsp_t rsp,          // Answer out
    input wire mmpc_pkg::mmpc_eff_t eff,          // Effective settings
    input wire logic                rf_rate_high  // High data rate
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic live; // Effective outputs hold real values; they read zero until the first enabled edge
    // Arms the setting checks one edge after the first enabled edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            live <= 1'b0;
        end else if (ce) begin
            live <= 1'b1;
        end
    end
    property p_rsp_cause;
        // Only an enabled edge refreshes the answer; a frozen answer is not a new one
        rsp.valid && $past(ce) |-> $past(cmd.wr || cmd.rd);
    endproperty
    a_rsp_cause: assert property (p_rsp_cause) else $error("answer without a command");
    property p_role_refuse;
        ce && cmd.wr && cmd.idx == 5'h04 && cmd.data == 32'h5 |=> rsp.valid && rsp.err;
    endproperty
    a_role_refuse: assert property (p_role_refuse) else $error("unused role accepted");
    property p_ro_refuse;
        ce && cmd.wr && cmd.idx inside {5'h02, 5'h03, 5'h0a, 5'h0b} |=> rsp.valid && rsp.err;
    endproperty
    a_ro_refuse: assert property (p_ro_refuse) else $error("read-only write accepted");
    property p_bad_read;
        ce && cmd.rd && !cmd.wr && cmd.idx > 5'h0f |=> rsp.err && rsp.data == 32'h0;
    endproperty
    a_bad_read: assert property (p_bad_read) else $error("unknown index answered");
    property p_bc_hops;
        live |-> eff.bc_hops <= 8'h20;
    endproperty
    a_bc_hops: assert property (p_bc_hops) else $error("broadcast hops above limit");
    property p_slots;
        live |-> eff.max_slots inside {[8'h01:8'h05]};
    endproperty
    a_slots: assert property (p_slots) else $error("delay slots out of range");
    property p_net_ack;
        live && eff.net_ack |-> eff.net_tries inside {[4'h2:4'h8]};
    endproperty
    a_net_ack: assert property (p_net_ack) else $error("acks with no retries");
    property p_no_ack;
        live && eff.net_tries == 4'h1 |-> !eff.net_ack;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("acks with zero retries");
    property p_rate0;
        live && !rf_rate_high |-> eff.dm == mmpc_pkg::MMPC_DM_P2MP;
    endproperty
    a_rate0: assert property (p_rate0) else $error("mesh delivery at low rate");
    c_role: cover property (p_role_refuse);
    c_ack: cover property (live && eff.net_ack);
    c_low: cover property (live && !rf_rate_high);
endmodule : mmpc_bank_monitor
bind mmpc_bank mmpc_bank_monitor u_mon (.clock(clock), .rst_n(rst_n), .ce(ce), .cmd(cmd), .rsp(rsp), .eff(eff),
                                        .rf_rate_high(rf_rate_high));

// ### mmpc_bank_tb_top.sv
// Testbench of the mesh parameter and counter bank
`timescale 1ns/100ps
module mmpc_bank_tb_top;
    typedef struct packed {logic [4:0] idx; logic [31:0] data; logic err; logic [31:0] back;} mmpc_row_t;
    logic                clock = 1'b0;       // System clock
    logic                rst_n = 1'b0;       // Reset, active low
    logic                en = 1'b1;          // Clock enable
    logic                fail_ev = 1'b0;     // Retry-exhausted events
    logic                ack_ev = 1'b0;      // Ack-request events
    logic                fo_valid = 1'b0;    // Per-frame options present
    logic [7:0]          fo = 8'h00;         // Per-frame options
    logic [63:0]         fa = 64'h0123_4567_89ab_cdef; // Arbitrary factory address
    mmpc_pkg::mmpc_cmd_t cmd;                // Host command
    mmpc_pkg::mmpc_rsp_t rsp, r;             // Answer and last taken answer
    mmpc_pkg::mmpc_eff_t eff;                // Effective settings
    logic                rate;               // High rate flag
    logic [15:0]         uc_to, bc_to;       // Hop timeouts
    logic [31:0]         rstv [16];          // Reset values by index
    logic [2:0]          rolex [7];          // Routing, hold, poll per role
    mmpc_row_t           rows [17];          // Write and read-back cases
    int                  fails = 0, n_checks = 0, cycles = 0;
    mmpc_bank dut (.clock(clock), .rst_n(rst_n), .ce(en), .cmd(cmd), .factory_addr(fa), .tx_retry_fail(fail_ev),
                   .tx_ack_unicast(ack_ev), .frame_opt_valid(fo_valid), .per_frame_tx_options(fo), .rsp(rsp),
                   .eff(eff), .rf_rate_high(rate), .unicast_hop_timeout(uc_to), .broadcast_hop_timeout(bc_to));
    mmpc_host_model u_host (.rsp(rsp), .clock(clock), .cmd(cmd));
    always #5 clock = ~clock;
    // Cuts a hang short; the whole run needs a few hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] idx, input logic [31:0] data, input logic err);
        u_host.xfer(1'b1, idx, data, r);
        chk(64'({r.valid, r.err}), 64'({1'b1, err}));
    endtask : wr
    task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
        u_host.xfer(1'b0, idx, 32'h0, r);
        chk(64'({r.valid, r.err, r.data}), 64'({2'b10, exp}));
    endtask : rd
    // Effective outputs trail the register by a cycle; give them room
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask : settle
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        rstv = '{32'h0, 32'h0, 32'hf3, 32'h204, 32'h0, 32'h4, 32'h0, 32'h7, 32'h3, 32'h1, fa[63:32], fa[31:0],
                 32'h0, 32'hffff, 32'hc0, 32'h1};
        rolex = '{3'b100, 3'b110, 3'b000, 3'b010, 3'b101, 3'b000, 3'b001};
        rows = '{'{5'h02, 32'h1, 1'b1, 32'hf3}, '{5'h03, 32'h1, 1'b1, 32'h204}, '{5'h0a, 32'h1, 1'b1, fa[63:32]},
                 '{5'h04, 32'h5, 1'b1, 32'h0}, '{5'h04, 32'h6, 1'b0, 32'h6}, '{5'h04, 32'h7, 1'b1, 32'h6},
                 '{5'h06, 32'h21, 1'b1, 32'h0}, '{5'h06, 32'h20, 1'b0, 32'h20}, '{5'h07, 32'h0, 1'b1, 32'h7},
                 '{5'h08, 32'h6, 1'b1, 32'h3}, '{5'h08, 32'h1, 1'b0, 32'h1}, '{5'h09, 32'h8, 1'b1, 32'h1},
                 '{5'h0e, 32'hd0, 1'b1, 32'hc0}, '{5'h0e, 32'h0f, 1'b1, 32'hc0}, '{5'h0e, 32'h8f, 1'b0, 32'h8f},
                 '{5'h00, 32'h10000, 1'b1, 32'h0}, '{5'h00, 32'hfffe, 1'b0, 32'hfffe}};
        repeat (16) @(negedge clock);
        chk(64'({uc_to, bc_to}), 64'h00f3_0204);
        rst_n = 1'b1;
        settle();
        chk(eff.dest, 64'h0000_0000_0000_ffff);
        for (int i = 0; i < 16; i++) rd(5'(i), rstv[i]);
        // Table rows: refused writes leave the old value, the rest read back
        for (int i = 0; i < 17; i++) begin
            wr(rows[i].idx, rows[i].data, rows[i].err);
            rd(rows[i].idx, rows[i].back);
        end
        u_host.xfer(1'b0, 5'h10, 32'h0, r);
        chk(64'({r.valid, r.err, r.data}), {30'h0, 2'b11, 32'h0});
        // Both counters count: failure saturates, unicast steps by one
        fail_ev = 1'b1;
        ack_ev = 1'b1;
        repeat (2) @(negedge clock);
        ack_ev = 1'b0;
        @(negedge clock);
        rd(5'h00, 32'hffff);
        rd(5'h01, 32'h2);
        wr(5'h00, 32'h5, 1'b0);
        fail_ev = 1'b0;
        rd(5'h00, 32'h5);
        wr(5'h07, 32'h8, 1'b0);
        settle();
        chk(64'({uc_to, bc_to}), 64'h0103_0224);
        wr(5'h07, 32'h3, 1'b0);
        settle();
        chk(64'({uc_to, bc_to, eff.bc_hops, eff.max_slots}), 64'h00b3_0184_03_01);
        wr(5'h05, 32'h0, 1'b0);
        settle();
        chk(64'(eff.enc_ecb), 64'h0);
        wr(5'h09, 32'h3, 1'b0);
        settle();
        chk(64'({eff.net_ack, eff.net_tries}), 64'h14);
        wr(5'h09, 32'h0, 1'b0);
        settle();
        chk(64'({eff.net_ack, eff.net_tries}), 64'h01);
        for (int i = 0; i < 7; i++) begin
            if (i != 5) begin
                wr(5'(i), 32'h0, i == 2 || i == 3);
                wr(5'h04, 32'(i), 1'b0);
                settle();
                chk(64'({eff.routing, eff.coord_hold, eff.poller}), 64'(rolex[i]));
            end
        end
        wr(5'h0c, 32'h1234_5678, 1'b0);
        wr(5'h0d, 32'h9abc_def0, 1'b0);
        settle();
        chk(eff.dest, 64'h1234_5678_9abc_def0);
        fo = 8'h4c;
        fo_valid = 1'b1;
        settle();
        chk(64'({eff.dm, eff.no_ack, eff.no_rd, eff.nack, eff.trace}), 64'h13);
        fo_valid = 1'b0;
        settle();
        chk(64'({eff.dm, eff.no_ack, eff.no_rd, eff.nack, eff.trace}), 64'h2f);
        wr(5'h0f, 32'h0, 1'b0);
        rd(5'h0e, 32'h40);
        wr(5'h0e, 32'hc1, 1'b0);
        rd(5'h0e, 32'h41);
        settle();
        chk(64'({rate, eff.dm}), 64'h1);
        wr(5'h0f, 32'h1, 1'b0);
        rd(5'h0e, 32'hc0);
        settle();
        chk(64'(rate), 64'h1);
        // Clock enable low freezes the counters although events keep coming
        en = 1'b0;
        fail_ev = 1'b1;
        ack_ev = 1'b1;
        repeat (3) @(negedge clock);
        {en, fail_ev, ack_ev} = 3'b100;
        rd(5'h00, 32'h0);
        rd(5'h01, 32'h0);
        wrap_up();
    end
endmodule : mmpc_bank_tb_top

// ### mmpc_cfg.svh
// Constants of the mesh parameter and counter bank
`ifndef MMPC_CFG_SVH
`define MMPC_CFG_SVH
// Parameter indices on the command port
`define MMPC_IDX_TXFAIL    5'h00
`define MMPC_IDX_UCREQ     5'h01
`define MMPC_IDX_UCHOP     5'h02
`define MMPC_IDX_BCHOP     5'h03
`define MMPC_IDX_ROLE      5'h04
`define MMPC_IDX_COMPAT    5'h05
`define MMPC_IDX_BHOPS     5'h06
`define MMPC_IDX_NHOPS     5'h07
`define MMPC_IDX_SLOTS     5'h08
`define MMPC_IDX_MRETRY    5'h09
`define MMPC_IDX_OWNHI     5'h0a
`define MMPC_IDX_OWNLO     5'h0b
`define MMPC_IDX_DESTHI    5'h0c
`define MMPC_IDX_DESTLO    5'h0d
`define MMPC_IDX_TXOPT     5'h0e
`define MMPC_IDX_RATE      5'h0f
// Reset values
`define MMPC_RST_UCHOP     16'h00f3
`define MMPC_RST_BCHOP     16'h0204
`define MMPC_RST_ROLE      8'h00
`define MMPC_RST_COMPAT    8'h04
`define MMPC_RST_BHOPS     8'h00
`define MMPC_RST_NHOPS     8'h07
`define MMPC_RST_SLOTS     8'h03
`define MMPC_RST_MRETRY    8'h01
`define MMPC_RST_DESTHI    32'h0000_0000
`define MMPC_RST_DESTLO    32'h0000_ffff
`define MMPC_RST_TXOPT_R0  8'h40
`define MMPC_RST_TXOPT_R1  8'hc0
`define MMPC_RST_RATE      1'b1
// Limits
`define MMPC_CNT_MAX       16'hffff
`define MMPC_ROLE_MAX      8'h06
`define MMPC_ROLE_UNUSED   8'h05
`define MMPC_HOPS_MAX      8'h20
`define MMPC_SLOTS_MAX     8'h05
`define MMPC_MRETRY_MAX    8'h07
// Field positions
`define MMPC_COMPAT_ENC    2
`define MMPC_TXO_DM_HI     7
`define MMPC_TXO_DM_LO     6
`define MMPC_TXO_RSV_HI    5
`define MMPC_TXO_RSV_LO    4
`define MMPC_TXO_TRACE     3
`define MMPC_TXO_NACK      2
`define MMPC_TXO_NORD      1
`define MMPC_TXO_NOACK     0
// Hop timeout scaling per hop in ms beyond the default of 7
`define MMPC_UCHOP_STEP    16'h0010
`define MMPC_BCHOP_STEP    16'h0020
`endif

// ### mmpc_host_model.sv
// Host model issuing parameter commands to the bank
`timescale 1ns/100ps
module mmpc_host_model (
    input  wire mmpc_pkg::mmpc_rsp_t rsp,   // Answer from the bank
    input  wire logic                clock, // System clock
    output mmpc_pkg::mmpc_cmd_t      cmd    // Command to the bank
);
    initial cmd = '0;
    // One command: raised after a falling edge, taken at the rising edge,
    // answer picked up at the next falling edge while it stands
    task automatic xfer(input logic wr, input logic [4:0] idx, input logic [31:0] data,
                        output mmpc_pkg::mmpc_rsp_t r);
        logic [31:0] arg;
        arg = (idx == 5'h05) ? (data & 32'h4) : data;
        @(negedge clock);
        cmd = {wr, !wr, idx, arg};
        @(negedge clock);
        r = rsp;
        cmd = '0;
    endtask : xfer
endmodule : mmpc_host_model

// ### mmpc_pkg.sv
// Types of the mesh parameter and counter bank
package mmpc_pkg;
    // Delivery method codes
    typedef enum logic [1:0] {
        MMPC_DM_INVALID = 2'h0,
        MMPC_DM_P2MP    = 2'h1,
        MMPC_DM_REPEAT  = 2'h2,
        MMPC_DM_MESH    = 2'h3
    } mmpc_dm_t;
    // Command from the serial command decoder
    typedef struct packed {
        logic        wr;     // Write with argument
        logic        rd;     // Read request
        logic [4:0]  idx;    // Parameter index
        logic [31:0] data;   // Argument
    } mmpc_cmd_t;
    // Answer to the command decoder
    typedef struct packed {
        logic        valid;  // Answer strobe
        logic        err;    // Rejected or unknown
        logic [31:0] data;   // Read value
    } mmpc_rsp_t;
    // Effective settings toward the mesh logic
    typedef struct packed {
        mmpc_dm_t    dm;           // Delivery method
        logic        no_ack;       // Unicast ack off
        logic        no_rd;        // Route discovery off
        logic        nack;         // Negative ack on
        logic        trace;        // Trace route on
        logic        enc_ecb;      // AES ECB 128 when set, CTR 256 when clear
        logic        routing;      // Repeats broadcasts
        logic        coord_hold;   // Holds indirect unicasts
        logic        poller;       // Sends polls
        logic        net_ack;      // Network acks requested
        logic [3:0]  net_tries;    // Retry setting plus one
        logic [7:0]  bc_hops;      // Effective broadcast hops
        logic [7:0]  max_slots;    // Max delay slots
        logic [63:0] dest;         // Transparent destination
    } mmpc_eff_t;
endpackage : mmpc_pkg

// ### mmpc_sat_counter.sv
// Saturating 16-bit event counter with preset
`timescale 1ns/100ps
`include "mmpc_cfg.svh"
module mmpc_sat_counter (
    input  wire logic        clock,   // System clock
    input  wire logic        rst_n,   // Async reset, active low
    input  wire logic        ce,      // Clock enable
    input  wire logic        load,    // Preset strobe
    input  wire logic [15:0] load_value, // Preset value
    input  wire logic        event_in,   // Qualifying event
    output logic [15:0]      count    // Counter value
);
    // Preset first, then a single-step saturating increment
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
        end else if (ce) begin
            if (load) begin
                count <= load_value;
            end else if (event_in && count != `MMPC_CNT_MAX) begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule : mmpc_sat_counter
